// *** pirqe_enable.sv ***
// Peripheral interrupt enable register with its flag register and a
// combined request output, reached over Avalon-MM.
// Assumes sources present one-cycle event pulses synchronous to core_clk.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps

// Notes on behaviour
// - Serial transmit request passes only while its enable bit 4 is one.
// - Capture/compare request passes only while enable bit 2 is one.
// - Timer B period-match request passes only while enable bit 1 is one.
// - Timer A overflow request passes only while enable bit 0 is one.
// - Flags set on source events regardless of any enable bit.
module pirqe_enable
   import pirqe_pkg::*;
#(
   parameter int ADDR_W = 10
)
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   // Source event pulses, bit order as the enable register
   input  wire logic [7:0]        source_event,
   // Current enable view, combined request
   output logic      [7:0]        serial_irq_view,
   output logic                   peripheral_irq_request
);

   // Address bits above the ten decoded ones are ignored
   if (ADDR_W < 10)
   begin : g_addr_check
      $error("pirqe_enable: ADDR_W below the ten decoded address bits");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pirqe_state_t state;
   pirqe_state_t next_state;

   localparam int NUM_SRC = $bits(PIRQE_IMPL_MASK);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------

   // Word match; the two byte-offset bits are ignored
   function automatic logic hits_offset
   (
      input logic [9:0] byte_addr,
      input logic [9:0] offset
   );
      logic [9:0] aligned;
      logic       match;
      aligned = {byte_addr[9:2], 2'h0};
      match = (aligned == offset);
      return match;
   endfunction

   // Byte registers sit in lane 0; upper lanes read zero
   function automatic logic [31:0] lane0_word
   (
      input logic [7:0] value
   );
      logic [31:0] word;
      word = {24'h000000, value};
      return word;
   endfunction

   // Control bits sit at the bottom of their word
   function automatic logic [31:0] ctrl_word
   (
      input logic [1:0] value
   );
      logic [31:0] word;
      word = {30'h0, value};
      return word;
   endfunction

   // Control field of a write word
   function automatic logic [1:0] ctrl_from_write
   (
      input logic [31:0] data
   );
      logic [1:0] bits;
      bits = data[1:0];
      return bits;
   endfunction

   // Unimplemented positions never hold a one
   function automatic logic [7:0] implemented
   (
      input logic [7:0] value
   );
      logic [7:0] kept;
      kept = value & PIRQE_IMPL_MASK;
      return kept;
   endfunction

   // Write-one-to-clear keeps software from racing a new event
   function automatic logic [7:0] clear_ones
   (
      input logic [7:0] current,
      input logic [7:0] ones
   );
      logic [7:0] left;
      left = current & ~ones;
      return left;
   endfunction

   // ----------------------------------------------------------------
   // Bus request
   // ----------------------------------------------------------------

   // Handshake
   logic               bus_req;
   logic               bus_take;
   logic               bus_done;
   logic               lane0_on;
   // Register selects
   logic               sel_enable;
   logic               sel_flag;
   logic               sel_ctrl;
   // Write and read strobes
   logic               wr_enable;
   logic               wr_flag;
   logic               wr_ctrl;
   logic               rd_take;
   // Sources and gating
   logic [7:0]         event_in;
   logic [NUM_SRC-1:0] gated;
   logic               any_pass;
   logic               masters_on;

   // Taken while no answer is pending
   assign bus_req  = read | write;
   assign bus_take = bus_req & ~state.ack;
   // Writes land only at the edge that sees waitrequest low
   assign bus_done = bus_req & state.ack;
   // Each register fits in one byte, so only lane 0 matters
   assign lane0_on = byteenable[0];

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   assign sel_enable = hits_offset(address[9:0],
                                   PIRQE_ENABLE_OFFSET);

   assign sel_flag   = hits_offset(address[9:0],
                                   PIRQE_FLAG_OFFSET);

   assign sel_ctrl   = hits_offset(address[9:0],
                                   PIRQE_CTRL_OFFSET);

   // ----------------------------------------------------------------
   // Write and read strobes
   // ----------------------------------------------------------------

   assign wr_enable = bus_done
                      & write
                      & lane0_on
                      & sel_enable;

   assign wr_flag   = bus_done
                      & write
                      & lane0_on
                      & sel_flag;

   assign wr_ctrl   = bus_done
                      & write
                      & lane0_on
                      & sel_ctrl;

   // Read data captured at the taking edge, ready in the cycle after the wait cycle
   assign rd_take   = bus_take
                      & read;

   // ----------------------------------------------------------------
   // Source events
   // ----------------------------------------------------------------

   // Bit 3 has no source behind it
   assign event_in = implemented(source_event);

   // ----------------------------------------------------------------
   // Request gating
   // ----------------------------------------------------------------

   // Enables only gate requests; flags stay visible regardless
   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++)
      begin : g_gate
         assign gated[g] = state.flag[g]
                           & state.enable[g];
      end
   endgenerate

   assign any_pass   = |gated;

   // Both master enables must be on
   assign masters_on = state.ctrl[PIRQE_CTRL_GLOBAL]
                       & state.ctrl[PIRQE_CTRL_PERIPH];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   always_comb
   begin
      next_state = state;

      // One wait cycle per access, answer on the following edge
      if (bus_take)
      begin
         next_state.ack = 1'b1;
      end
      else
      begin
         next_state.ack = 1'b0;
      end

      // Enable register
      if (wr_enable)
      begin
         next_state.enable = implemented(writedata[7:0]);
      end

      // Master enables
      if (wr_ctrl)
      begin
         next_state.ctrl = ctrl_from_write(writedata);
      end

      // A same-cycle event wins over the clear, so no event is lost
      if (wr_flag)
      begin
         next_state.flag = clear_ones(state.flag, writedata[7:0]);
      end
      if (|event_in)
      begin
         next_state.flag = next_state.flag | event_in;
      end

      // Read data stand until the next read is taken
      if (rd_take)
      begin
         if (sel_enable)
         begin
            next_state.readdata = lane0_word(state.enable);
         end
         else if (sel_flag)
         begin
            next_state.readdata = lane0_word(state.flag);
         end
         else if (sel_ctrl)
         begin
            next_state.readdata = ctrl_word(state.ctrl);
         end
         else
         begin
            // Unmapped words read zero
            next_state.readdata = PIRQE_READ_ZERO;
         end
      end

      // Registered request, one cycle behind flag, enable and control
      if (masters_on & any_pass)
      begin
         next_state.irq = 1'b1;
      end
      else
      begin
         next_state.irq = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state.enable   <= PIRQE_ENABLE_RST;
         state.flag     <= PIRQE_FLAG_RST;
         state.ctrl     <= PIRQE_CTRL_RST;
         state.readdata <= PIRQE_READ_ZERO;
         state.ack      <= 1'b0;
         state.irq      <= 1'b0;
      end
      else
         state <= next_state;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign waitrequest            = bus_take;
   assign readdata               = state.readdata;
   assign serial_irq_view        = state.enable;
   assign peripheral_irq_request = state.irq;

endmodule

// *** pirqe_enable_asserts.sv ***
// Checker for the enable block: bus timing, enable view and request gating.
// Assumes it is bound onto pirqe_enable with the default address width.
`timescale 1ns/1ps
module pirqe_enable_asserts
   import pirqe_pkg::*;
(
   // Watched ports
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [9:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic [7:0]  serial_irq_view,
   input wire logic        peripheral_irq_request
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // View is the enable register itself, so it does not lag the state
   // Request is registered, so it follows the enables of the cycle before
   a_req_needs_en: assert property (
      peripheral_irq_request |-> $past(serial_irq_view) != 8'h00)
      else $error("request with no enable");
   a_bit3_zero: assert property (serial_irq_view[3] == 1'b0) else $error("bit 3 set");
   a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("more than one wait cycle");
   a_read_enable: assert property (
      read && !waitrequest && address == PIRQE_ENABLE_OFFSET |->
      readdata == {24'h000000, serial_irq_view}) else $error("enable readback");
   a_read_bit3: assert property (
      read && !waitrequest |-> readdata[3] == 1'b0) else $error("bit 3 read as one");
   a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
      else $error("wait with no request");
   a_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
      else $error("upper read bits set");
endmodule
bind pirqe_enable pirqe_enable_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .serial_irq_view(serial_irq_view),
   .peripheral_irq_request(peripheral_irq_request));

// *** pirqe_pkg.sv ***
// Package for the peripheral interrupt enable block: register map,
// field positions and reset values.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package pirqe_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [9:0] PIRQE_ENABLE_OFFSET = 10'h08c;
   localparam logic [9:0] PIRQE_FLAG_OFFSET   = 10'h090;
   localparam logic [9:0] PIRQE_CTRL_OFFSET   = 10'h094;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PIRQE_BIT_TMR_A_OVF = 0;
   localparam int PIRQE_BIT_TMR_B_MAT = 1;
   localparam int PIRQE_BIT_CAPCMP    = 2;
   localparam int PIRQE_BIT_UNUSED    = 3;
   localparam int PIRQE_BIT_SER_TX    = 4;
   localparam int PIRQE_BIT_SER_RX    = 5;
   localparam int PIRQE_BIT_CMP       = 6;
   localparam int PIRQE_BIT_EE        = 7;

   // Writable bits: bit 3 is unimplemented
   localparam logic [7:0] PIRQE_IMPL_MASK   = 8'hf7;
   localparam logic [7:0] PIRQE_ENABLE_RST  = 8'h00;
   localparam logic [7:0] PIRQE_FLAG_RST    = 8'h00;
   localparam logic [1:0] PIRQE_CTRL_RST    = 2'h0;
   localparam int         PIRQE_CTRL_GLOBAL = 1;
   localparam int         PIRQE_CTRL_PERIPH = 0;
   localparam logic [31:0] PIRQE_READ_ZERO  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  enable;
      logic [7:0]  flag;
      logic [1:0]  ctrl;
      logic [31:0] readdata;
      logic        ack;
      logic        irq;
   } pirqe_state_t;

endpackage

// *** testbench.sv ***
// Testbench: register access over Avalon-MM and per-source request gating.
// Assumes pirqe_enable with its default address width.
`timescale 1ns/1ps
module testbench;
   import pirqe_pkg::*;
   logic        core_clk, rst_n, read, write, peripheral_irq_request, waitrequest;
   logic [9:0]  address;
   logic [31:0] writedata, readdata, q;
   logic [3:0]  byteenable;
   logic [7:0]  source_event, serial_irq_view;
   int          num_errors, samples_checked, cycles;
   int          bits [5] = '{0, 1, 2, 4, 5};
   pirqe_enable dut (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .source_event(source_event),
      .serial_irq_view(serial_irq_view), .peripheral_irq_request(peripheral_irq_request));
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Hang guard, far above the fewer than two hundred cycles needed
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         summarize();
      end
   end
   task summarize;
      if (num_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Settled values at the falling edge are those the next rising edge takes
   task acc(input logic w, input logic [9:0] a, input logic [31:0] d);
      logic done;
      @(posedge core_clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      done = 1'b0;
      while (!done)
      begin
         @(negedge core_clk);
         done = (waitrequest === 1'b0);
         q = readdata;
         @(posedge core_clk);
      end
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task settle;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   initial
   begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 10'h000;
      writedata = 32'h0;
      byteenable = 4'hf;
      source_event = 8'h00;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      acc(1'b0, PIRQE_ENABLE_OFFSET, 32'h0);
      chk(q, {24'h0, PIRQE_ENABLE_RST});
      acc(1'b1, PIRQE_ENABLE_OFFSET, 32'hffffffff);
      acc(1'b0, PIRQE_ENABLE_OFFSET, 32'h0);
      chk(q, 32'h000000f7);
      byteenable <= 4'h0;
      acc(1'b1, PIRQE_ENABLE_OFFSET, 32'h0);
      byteenable <= 4'hf;
      acc(1'b1, 10'h3fc, 32'hffffffff);
      acc(1'b0, 10'h3fc, 32'h0);
      chk(q, 32'h0);
      acc(1'b0, PIRQE_ENABLE_OFFSET, 32'h0);
      chk(q, 32'h000000f7);
      acc(1'b1, PIRQE_CTRL_OFFSET, 32'h3);
      acc(1'b0, PIRQE_CTRL_OFFSET, 32'h0);
      chk(q, 32'h3);
      foreach (bits[i])
      begin
         acc(1'b1, PIRQE_ENABLE_OFFSET, 32'h0);
         @(posedge core_clk);
         source_event <= 8'h01 << bits[i];
         @(posedge core_clk);
         source_event <= 8'h00;
         acc(1'b0, PIRQE_FLAG_OFFSET, 32'h0);
         chk(q, 32'h1 << bits[i]);
         @(negedge core_clk);
         chk({31'h0, peripheral_irq_request}, 32'h0);
         acc(1'b1, PIRQE_ENABLE_OFFSET, 32'h1 << bits[i]);
         settle();
         chk({31'h0, peripheral_irq_request}, 32'h1);
         acc(1'b1, PIRQE_FLAG_OFFSET, 32'h1 << bits[i]);
         acc(1'b0, PIRQE_FLAG_OFFSET, 32'h0);
         chk(q, 32'h0);
      end
      // Event during the clearing write keeps the flag set
      source_event <= 8'h01;
      acc(1'b1, PIRQE_FLAG_OFFSET, 32'h1);
      source_event <= 8'h00;
      acc(1'b0, PIRQE_FLAG_OFFSET, 32'h0);
      chk(q, 32'h1);
      acc(1'b1, PIRQE_FLAG_OFFSET, 32'hff);
      acc(1'b1, PIRQE_ENABLE_OFFSET, 32'h1);
      settle();
      chk({31'h0, peripheral_irq_request}, 32'h0);
      acc(1'b1, PIRQE_CTRL_OFFSET, 32'h1);
      source_event <= 8'h01;
      @(posedge core_clk);
      source_event <= 8'h00;
      settle();
      chk({31'h0, peripheral_irq_request}, 32'h0);
      acc(1'b1, PIRQE_CTRL_OFFSET, 32'h3);
      settle();
      chk({31'h0, peripheral_irq_request}, 32'h1);
      // Second reset in mid-run
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      acc(1'b0, PIRQE_ENABLE_OFFSET, 32'h0);
      chk(q, {24'h0, PIRQE_ENABLE_RST});
      @(negedge core_clk);
      chk({31'h0, peripheral_irq_request}, 32'h0);
      summarize();
   end
endmodule
